// ==== sar_adc_three_wire_readout_tb.sv ====
// sar_adc_three_wire_readout_tb.sv: self-checking bench of the readout
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module sar_adc_three_wire_readout_tb;
    import sar_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b1;
    logic [SAR_AIN_W-1:0] level = '0;
    logic sclk, line, serial_result_out, oe, powered, chain, busy_f;
    logic [SAR_RES_W-1:0] result;
    logic [15:0] seed = 16'hf281;
    logic [16:0] v;
    logic oe_end;
    logic [20:0] tbl [4] = '{21'h000000, 21'h080000, 21'h07fff0,
        21'h0ffff0};
    int num_errors = 0;
    int n_checks = 0;
    int e_cut;
    int exp_q [$];
    always #10 mclk = ~mclk;
    sar_readout u_dut
    (
        .mclk_i(mclk),
        .rst_i(rst),
        .sclk_i(sclk),
        .conversion_start_line_i(line),
        .mode_select_serial_in_i(mode),
        .analog_level_i(level),
        .serial_result_out_o(serial_result_out),
        .serial_result_out_oe_o(oe),
        .powered_up_o(powered),
        .chain_mode_o(chain),
        .busy_bit_mode_o(busy_f),
        .result_o(result)
    );
    sar_host_model u_host
    (
        .mclk_i(mclk),
        .sdo_i(serial_result_out),
        .oe_i(oe),
        .sclk_o(sclk),
        .line_o(line)
    );
    // ********************************
    // reference model and frames
    // ********************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic start(input logic [20:0] lv, input logic busy);
        int e;
        e = int'(lv) / 16;
        if (e > 65535)
            e = 65535;
        exp_q.push_back(e);
        @(posedge mclk) level <= lv;
        // the input moves while converting; only the held sample counts
        fork
            u_host.conv(busy);
            begin
                repeat (14) @(posedge mclk);
                level <= ~lv;
            end
        join
    endtask : start
    task automatic run_frame(input logic [20:0] lv, input logic busy);
        int e;
        start(lv, busy);
        e = exp_q.pop_front();
        `CHK(powered, 1'b0)
        `CHK(busy_f, busy)
        `CHK(chain, 1'b0)
        `CHK(oe, busy)
        u_host.rd(busy ? 17 : 16, v, oe_end);
        `CHK(v, 17'(e))
        `CHK(oe_end, 1'b0)
        `CHK(result, 16'(e))
    endtask : run_frame
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // ********************************
    // main sequence and watchdog
    // ********************************
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            run_frame(i < 4 ? tbl[i] : {1'b0, seed, seed[3:0]}, i[0]);
        end
        // fifteen falls, then the line rise ends the frame before the 16th
        start(21'h0abcd0, 1'b0);
        e_cut = exp_q.pop_front();
        u_host.rd(15, v, oe_end);
        `CHK(v[14:0], 15'(e_cut >> 1))
        `CHK(serial_result_out, 1'(e_cut))
        `CHK(oe_end, 1'b1)
        run_frame(21'h012340, 1'b1);
        @(posedge mclk) mode <= 1'b0;
        u_host.conv(1'b0);
        `CHK(chain, 1'b1)
        `CHK(oe, 1'b0)
        mode <= 1'b1;
        run_frame(21'h0fffff, 1'b0);
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule : sar_adc_three_wire_readout_tb

// ==== sar_host_model.sv ====
// sar_host_model.sv: behavioural host driving the three-wire link
`timescale 1ns/1ps
module sar_host_model
(
    input wire logic mclk_i,
    input wire logic sdo_i,
    input wire logic oe_i,
    output logic sclk_o,
    output logic line_o
);
    // ********************************
    // host side of the link
    // ********************************
    logic sdo_w;
    // a released output reads as z so a stale bit never matches
    assign sdo_w = oe_i ? sdo_i : 1'bz;
    initial
    begin
        sclk_o = 1'b1;
        line_o = 1'b1;
    end
    task automatic conv(input logic busy);
        if (line_o)
        begin
            @(posedge mclk_i) line_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
        @(posedge mclk_i) line_o <= 1'b1;
        repeat (5) @(posedge mclk_i);
        line_o <= 1'b0;
        if (!busy)
        begin
            repeat (10) @(posedge mclk_i);
            line_o <= 1'b1;
        end
        else
        begin
            // clock running during conversion must do no harm
            repeat (3)
            begin
                #32 sclk_o = 1'b0;
                #32 sclk_o = 1'b1;
            end
        end
        repeat (75) @(posedge mclk_i);
    endtask : conv
    task automatic rd(input int n, output logic [16:0] v,
        output logic oe_end);
        v = 17'h00000;
        if (line_o)
        begin
            @(posedge mclk_i) line_o <= 1'b0;
            repeat (10) @(posedge mclk_i);
        end
        for (int i = 0; i < n; i++)
        begin
            v = {v[15:0], sdo_w};
            // 64 ns period; the bit is taken 1 ns ahead of each fall
            #1 sclk_o = 1'b0;
            #32 sclk_o = 1'b1;
            #31;
        end
        oe_end = oe_i;
    endtask : rd
endmodule : sar_host_model

// ==== sar_pkg.sv ====
// sar_pkg.sv: constants and types of the converter sequencing and readout
package sar_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int SAR_RES_W = 16;
    localparam int SAR_FRAC_W = 4;
    // input level in steps of reference / 2^20; one extra bit reaches vref
    localparam int SAR_AIN_W = SAR_RES_W + SAR_FRAC_W + 1;
    localparam int EDGE_CNT_W = 5;
    localparam int CONV_CNT_W = 7;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 1400;
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST =
        CONV_CNT_W'(CONV_CYCLES - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 7'h00;
    localparam logic [CONV_CNT_W-1:0] CONV_ONE = 7'h01;

    // ****************************************************************
    // codes and counts
    // ****************************************************************
    localparam logic [SAR_RES_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [SAR_RES_W-1:0] CODE_MID = 16'h8000;
    localparam logic [SAR_FRAC_W-1:0] FRAC_PAD = 4'h0;
    localparam logic [EDGE_CNT_W-1:0] EDGE_ZERO = 5'h00;
    localparam logic [EDGE_CNT_W-1:0] EDGE_ONE = 5'h01;
    localparam logic [EDGE_CNT_W-1:0] BITS_PLAIN = 5'h10;
    localparam logic [EDGE_CNT_W-1:0] BITS_BUSY = 5'h11;
    localparam logic BUSY_LEVEL = 1'b0;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_ACQ_IDLE = 5'b00001,
        ST_CONVERT = 5'b00010,
        ST_WAIT_SEL = 5'b00100,
        ST_SHIFT = 5'b01000,
        ST_HOLD = 5'b10000
    } sar_state_t;

endpackage : sar_pkg

// ==== sar_readout.sv ====
// sar_readout.sv: conversion sequencing and chip-select serial readout
`timescale 1ns/1ps
module sar_readout
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic conversion_start_line_i,
    input wire logic mode_select_serial_in_i,
    input wire logic [sar_pkg::SAR_AIN_W-1:0] analog_level_i,
    output logic serial_result_out_o,
    output logic serial_result_out_oe_o,
    output logic powered_up_o,
    output logic chain_mode_o,
    output logic busy_bit_mode_o,
    output logic [sar_pkg::SAR_RES_W-1:0] result_o
);
    import sar_pkg::*;

    // ****************************************************************
    // serial clock domain: falling-edge counter
    // ****************************************************************
    // the serial clock may stop between frames, so this domain only
    // counts edges; everything that needs a decision lives on mclk_i
    logic [EDGE_CNT_W-1:0] fall_cnt_r;
    logic [EDGE_CNT_W-1:0] fall_cnt_nxt;
    logic [EDGE_CNT_W-1:0] fall_gray_r;

    assign fall_cnt_nxt = fall_cnt_r + EDGE_ONE;

    always_ff @(negedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fall_cnt_r <= EDGE_ZERO;
            fall_gray_r <= EDGE_ZERO;
        end
        else
        begin
            fall_cnt_r <= fall_cnt_nxt;
            fall_gray_r <= fall_cnt_nxt ^ (fall_cnt_nxt >> 1);
        end
    end

    // ****************************************************************
    // crossings into the master clock domain
    // ****************************************************************
    logic start_line_s;
    logic mode_sel_s;
    logic [EDGE_CNT_W-1:0] fall_gray_s;

    // the start line idles high, so its stages reset high to avoid a
    // false rising edge right after reset
    sar_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_sync_start (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(conversion_start_line_i),
        .q_o(start_line_s)
    );

    sar_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_sync_mode (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(mode_select_serial_in_i),
        .q_o(mode_sel_s)
    );

    // gray code changes one bit per edge, so a sample mid-change is
    // either the old or the new count
    sar_sync #(
        .WIDTH(EDGE_CNT_W),
        .RST_VAL(EDGE_ZERO)
    ) u_sync_edges (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(fall_gray_r),
        .q_o(fall_gray_s)
    );

    function automatic logic [EDGE_CNT_W-1:0] gray_to_bin(
        input logic [EDGE_CNT_W-1:0] g
    );
        logic [EDGE_CNT_W-1:0] b;
        b[EDGE_CNT_W-1] = g[EDGE_CNT_W-1];
        for (int i = EDGE_CNT_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    // ****************************************************************
    // start line edges
    // ****************************************************************
    logic start_prev_r;
    logic start_rise;
    logic start_fall;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            start_prev_r <= 1'b1;
        else
            start_prev_r <= start_line_s;
    end

    assign start_rise = start_line_s & ~start_prev_r;
    assign start_fall = ~start_line_s & start_prev_r;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    sar_state_t state_r;
    sar_state_t state_nxt;
    logic [CONV_CNT_W-1:0] conv_cnt_r;
    logic conv_last;
    logic conv_begin;
    logic busy_at_end;
    logic chain_mode_r;
    logic busy_mode_r;
    logic [EDGE_CNT_W-1:0] edge_now;
    logic [EDGE_CNT_W-1:0] edge_base_r;
    logic [EDGE_CNT_W-1:0] edges_seen;
    logic shift_done;

    assign edge_now = gray_to_bin(fall_gray_s);
    assign edges_seen = edge_now - edge_base_r;
    // a rising edge while converting is ignored
    assign conv_begin = start_rise && (state_r != ST_CONVERT);
    assign conv_last = (state_r == ST_CONVERT) && (conv_cnt_r == CONV_LAST);
    assign busy_at_end = ~start_line_s;
    assign shift_done = busy_mode_r ? (edges_seen >= BITS_BUSY)
                                    : (edges_seen >= BITS_PLAIN);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_CONVERT:
            begin
                if (conv_last)
                begin
                    if (chain_mode_r)
                        state_nxt = ST_HOLD;
                    else if (busy_at_end)
                        state_nxt = ST_SHIFT;
                    else
                        state_nxt = ST_WAIT_SEL;
                end
            end
            ST_ACQ_IDLE, ST_HOLD:
            begin
                if (conv_begin)
                    state_nxt = ST_CONVERT;
            end
            ST_WAIT_SEL:
            begin
                if (conv_begin)
                    state_nxt = ST_CONVERT;
                else if (start_fall)
                    state_nxt = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (conv_begin)
                    state_nxt = ST_CONVERT;
                else if (shift_done)
                    state_nxt = ST_HOLD;
            end
            default:
                state_nxt = ST_ACQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            state_r <= ST_ACQ_IDLE;
        else
            state_r <= state_nxt;
    end

    // conversion length comes from mclk_i alone, never the serial clock
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            conv_cnt_r <= CONV_ZERO;
        else if (conv_begin)
            conv_cnt_r <= CONV_ZERO;
        else if (state_r == ST_CONVERT)
            conv_cnt_r <= conv_cnt_r + CONV_ONE;
    end

    // ****************************************************************
    // mode capture
    // ****************************************************************
    // daisy-chain output is not provided; here chain mode only keeps the
    // output floating after conversion
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            chain_mode_r <= 1'b0;
            busy_mode_r <= 1'b0;
        end
        else
        begin
            if (conv_begin)
                chain_mode_r <= ~mode_sel_s;
            if (conv_last)
                busy_mode_r <= busy_at_end;
        end
    end

    // ****************************************************************
    // successive approximation
    // ****************************************************************
    logic [SAR_AIN_W-1:0] held_level_r;
    logic [SAR_RES_W-1:0] code_r;
    logic [SAR_RES_W-1:0] trial_mask_r;
    logic [SAR_RES_W-1:0] trial_code;
    logic [SAR_RES_W-1:0] result_r;
    logic trial_keep;

    assign trial_code = code_r | trial_mask_r;
    // step is vref / 65536; an input at or above vref saturates at ffff
    assign trial_keep = {1'b0, trial_code, FRAC_PAD} <= held_level_r;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            held_level_r <= '0;
            code_r <= CODE_ZERO;
            trial_mask_r <= CODE_ZERO;
        end
        else if (conv_begin)
        begin
            held_level_r <= analog_level_i;
            code_r <= CODE_ZERO;
            trial_mask_r <= CODE_MID;
        end
        else if ((state_r == ST_CONVERT) && (trial_mask_r != CODE_ZERO))
        begin
            if (trial_keep)
                code_r <= trial_code;
            trial_mask_r <= trial_mask_r >> 1;
        end
    end

    // the old word stays in place through acquisition and is replaced
    // only when the new one is complete
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            result_r <= CODE_ZERO;
        else if (conv_last)
            result_r <= code_r;
    end

    // ****************************************************************
    // serial output
    // ****************************************************************
    logic [EDGE_CNT_W-1:0] bit_idx;
    logic data_bit;
    logic sdo_r;
    logic sdo_oe_r;

    assign bit_idx = busy_mode_r ? (BITS_BUSY - EDGE_ONE - edges_seen)
                                 : (BITS_PLAIN - EDGE_ONE - edges_seen);
    assign data_bit = (busy_mode_r && (edges_seen == EDGE_ZERO))
                      ? BUSY_LEVEL
                      : result_r[bit_idx[3:0]];

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            edge_base_r <= EDGE_ZERO;
        else if (conv_last || ((state_r == ST_WAIT_SEL) && start_fall))
            edge_base_r <= edge_now;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else if (conv_begin || start_rise)
        begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else if (conv_last)
        begin
            sdo_r <= BUSY_LEVEL;
            sdo_oe_r <= busy_at_end && !chain_mode_r;
        end
        else if ((state_r == ST_WAIT_SEL) && start_fall)
        begin
            sdo_r <= result_r[SAR_RES_W-1];
            sdo_oe_r <= 1'b1;
        end
        else if (state_r == ST_SHIFT)
        begin
            if (shift_done)
                sdo_oe_r <= 1'b0;
            else
                sdo_r <= data_bit;
        end
    end

    // ****************************************************************
    // power state
    // ****************************************************************
    logic powered_r;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            powered_r <= 1'b0;
        else if (conv_begin)
            powered_r <= 1'b1;
        else if (conv_last)
            powered_r <= 1'b0;
    end

    assign serial_result_out_o = sdo_r;
    assign serial_result_out_oe_o = sdo_oe_r;
    assign powered_up_o = powered_r;
    assign chain_mode_o = chain_mode_r;
    assign busy_bit_mode_o = busy_mode_r;
    assign result_o = result_r;

endmodule : sar_readout

// ==== sar_readout_asserts.sv ====
// sar_readout_asserts.sv: port-level assertions of the readout sequencer
`timescale 1ns/1ps
module sar_readout_asserts
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic conversion_start_line_i,
    input wire logic mode_select_serial_in_i,
    input wire logic [sar_pkg::SAR_AIN_W-1:0] analog_level_i,
    input wire logic serial_result_out_o,
    input wire logic serial_result_out_oe_o,
    input wire logic powered_up_o,
    input wire logic chain_mode_o,
    input wire logic busy_bit_mode_o,
    input wire logic [sar_pkg::SAR_RES_W-1:0] result_o
);
    import sar_pkg::*;
    // ********************************
    // powered cycle count
    // ********************************
    logic [7:0] pw_cnt_r;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            pw_cnt_r <= 8'h00;
        else if (powered_up_o)
            pw_cnt_r <= pw_cnt_r + 8'h01;
        else
            pw_cnt_r <= 8'h00;
    end
    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    conv_length_a: assert property (
        $fell(powered_up_o) |-> pw_cnt_r == 8'(CONV_CYCLES))
        else $error("conversion length wrong");
    conv_bound_a: assert property (
        pw_cnt_r <= 8'(CONV_CYCLES)) else $error("conversion overran");
    conv_quiet_a: assert property (
        powered_up_o |-> !serial_result_out_oe_o)
        else $error("output driven while converting");
    result_hold_a: assert property (
        $changed(result_o) |-> $fell(powered_up_o))
        else $error("result moved outside conversion end");
    busy_hold_a: assert property (
        $changed(busy_bit_mode_o) |-> $fell(powered_up_o))
        else $error("busy choice moved outside conversion end");
    busy_lead_a: assert property (
        $fell(powered_up_o) && busy_bit_mode_o && !chain_mode_o |->
        serial_result_out_oe_o && serial_result_out_o == BUSY_LEVEL)
        else $error("busy bit missing");
    plain_wait_a: assert property (
        $fell(powered_up_o) && !busy_bit_mode_o |-> !serial_result_out_oe_o)
        else $error("output enabled before select");
    line_float_a: assert property (
        conversion_start_line_i [*6] |-> !serial_result_out_oe_o)
        else $error("output driven while line high");
    msb_first_a: assert property (
        $rose(serial_result_out_oe_o) && !busy_bit_mode_o |->
        serial_result_out_o == result_o[15]) else $error("first bit not msb");
    chain_float_a: assert property (
        chain_mode_o |-> !serial_result_out_oe_o)
        else $error("output driven in chain mode");
    cover property ($rose(serial_result_out_oe_o) && !busy_bit_mode_o);
    cover property ($fell(powered_up_o) && busy_bit_mode_o);
    cover property ($rose(chain_mode_o));
endmodule : sar_readout_asserts

bind sar_readout sar_readout_asserts u_chk
(
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .conversion_start_line_i(conversion_start_line_i),
    .mode_select_serial_in_i(mode_select_serial_in_i),
    .analog_level_i(analog_level_i),
    .serial_result_out_o(serial_result_out_o),
    .serial_result_out_oe_o(serial_result_out_oe_o),
    .powered_up_o(powered_up_o),
    .chain_mode_o(chain_mode_o),
    .busy_bit_mode_o(busy_bit_mode_o),
    .result_o(result_o)
);

// ==== sar_sync.sv ====
// sar_sync.sv: two-flop synchroniser with a constant reset value
`timescale 1ns/1ps
module sar_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    // first stage is read by the second stage only
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule : sar_sync
